// ---- rtl/bmpm_pkg.sv ----
// constants and types for the boot mode and program map block
package bmpm_pkg;

	// ***************************************************************
	// address map
	// ***************************************************************
	localparam int          ADDR_W       = 21;
	localparam logic [20:0] PF0_END      = 21'h0_FFFF;
	localparam logic [20:0] PF1_END      = 21'h1_FFFF;
	localparam logic [20:0] BOOT_BASE    = 21'h2_0000;
	localparam logic [20:0] BOOT_END     = 21'h2_1FFF;
	localparam logic [20:0] PRAM_BASE    = 21'h2_F800;
	localparam logic [20:0] PRAM_END     = 21'h2_FFFF;
	localparam logic [20:0] EXT_MID_BASE = 21'h3_0000;
	localparam logic [20:0] HIGH_BASE    = 21'h10_0000;
	localparam logic [20:0] EXT_RAM_BASE = 21'h0_0000;
	localparam logic [20:0] WDOG_OFS     = 21'h0_0002;

	// ***************************************************************
	// startup and sizes
	// ***************************************************************
	localparam int         SYNC_STAGES = 2;
	localparam int         NUM_BANKS   = 2;
	localparam logic [3:0] GPIO_ADDR_ON  = 4'hF;
	localparam logic [3:0] GPIO_ADDR_OFF = 4'h0;
	localparam logic [3:0] UPPER_ADDR_OFF = 4'h0;

	// ***************************************************************
	// types
	// ***************************************************************
	typedef enum logic [2:0]
	{
		ST_SYNC    = 3'b001,
		ST_CAPTURE = 3'b010,
		ST_RUN     = 3'b100
	} bmpm_state_e;

	typedef enum logic [5:0]
	{
		TGT_NONE = 6'b00_0001,
		TGT_PF0  = 6'b00_0010,
		TGT_PF1  = 6'b00_0100,
		TGT_BOOT = 6'b00_1000,
		TGT_PRAM = 6'b01_0000,
		TGT_EXT  = 6'b10_0000
	} bmpm_tgt_e;

endpackage

// ---- rtl/bmpm_map_decode.sv ----
// program space address decoder for the current map
`timescale 1ns/1ps
module bmpm_map_decode
(
	// mode
	input  wire logic                   i_ready,
	input  wire logic                   i_map_ext,
	input  wire logic                   i_wide,
	// address
	input  wire logic [20:0]            i_addr,
	// result
	output bmpm_pkg::bmpm_tgt_e         o_tgt,
	output logic [20:0]                 o_boot_vec,
	output logic [20:0]                 o_wdog_vec
);

	// ***************************************************************
	// target select
	// ***************************************************************
	// priority follows address order; gaps answer with no target
	always_comb
	begin
		o_tgt = bmpm_pkg::TGT_NONE;
		if (!i_ready)
			o_tgt = bmpm_pkg::TGT_NONE;
		else if (i_addr >= bmpm_pkg::HIGH_BASE)
			o_tgt = bmpm_pkg::TGT_NONE;
		else if (i_addr <= bmpm_pkg::PF0_END)
			o_tgt = i_map_ext ? bmpm_pkg::TGT_EXT : bmpm_pkg::TGT_PF0;
		else if (i_addr <= bmpm_pkg::PF1_END)
			o_tgt = bmpm_pkg::TGT_PF1;
		else if (i_addr <= bmpm_pkg::BOOT_END)
			o_tgt = (i_map_ext && i_wide) ? bmpm_pkg::TGT_EXT : bmpm_pkg::TGT_BOOT;
		else if (i_addr >= bmpm_pkg::PRAM_BASE && i_addr <= bmpm_pkg::PRAM_END)
			o_tgt = bmpm_pkg::TGT_PRAM;
		else if (i_addr >= bmpm_pkg::EXT_MID_BASE && i_map_ext && i_wide)
			o_tgt = bmpm_pkg::TGT_EXT; // only a 20-bit bus reaches here
		else
			o_tgt = bmpm_pkg::TGT_NONE;
	end

	// ***************************************************************
	// vectors
	// ***************************************************************
	always_comb
	begin
		o_boot_vec = bmpm_pkg::BOOT_BASE;
		if (i_map_ext && !i_wide)
			o_boot_vec = bmpm_pkg::EXT_RAM_BASE;
		o_wdog_vec = o_boot_vec + bmpm_pkg::WDOG_OFS;
	end

endmodule

// ---- rtl/bmpm_bank_guard.sv ----
// per-bank guard for flash program and mass erase against fetches
`timescale 1ns/1ps
module bmpm_bank_guard
#(
	parameter int NB = 2
)
(
	// bank activity
	input  wire logic [NB-1:0] i_fetch,
	// requests
	input  wire logic [NB-1:0] i_pgm_req,
	input  wire logic [NB-1:0] i_erase_req,
	// grants
	output logic [NB-1:0]      o_pgm_go,
	output logic [NB-1:0]      o_erase_go
);

	// ***************************************************************
	// one guard per bank
	// ***************************************************************
	// a bank may be altered only while code is not running from it
	genvar b;
	generate
		for (b = 0; b < NB; b++)
		begin : g_bank
			assign o_pgm_go[b]   = i_pgm_req[b] & ~i_fetch[b];
			assign o_erase_go[b] = i_erase_req[b] & ~i_fetch[b];
		end
	endgenerate

endmodule

// ---- rtl/bmpm_top.sv ----
// boot mode capture, operating mode bits and program map decode
`timescale 1ns/1ps
module bmpm_top
(
	// clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RESETN,
	// pins and flash state
	input  wire logic        I_EXTERNAL_BOOT_PIN,
	input  wire logic        I_WIDE_ADDRESS_SELECT,
	input  wire logic        I_FLASH_UNSECURED,
	// operating mode register write
	input  wire logic        I_OPMODE_WR,
	input  wire logic        I_OPMODE_SECURE_STATE_BIT,
	input  wire logic        I_OPMODE_BOOT_MAP_SELECT,
	// program fetch address
	input  wire logic        I_PVALID,
	input  wire logic [20:0] I_PADDR,
	// flash bank requests
	input  wire logic [1:0]  I_PGM_REQ,
	input  wire logic [1:0]  I_ERASE_REQ,
	// data flash read requests
	input  wire logic        I_DF_RD_CORE,
	input  wire logic        I_DF_RD_SEC,
	// mode status
	output logic             O_READY,
	output logic             O_SECURE_STATE_BIT,
	output logic             O_BOOT_MAP_SELECT,
	output logic             O_ADDR_WIDE,
	output logic [3:0]       O_GPIO_AS_ADDR,
	output logic [3:0]       O_UPPER_ADDR_EN,
	output logic             O_DEBUG_DISABLE,
	output logic             O_FIRST_CS_PROG_STROBE,
	output logic             O_SECOND_CS_DATA_STROBE,
	// vectors
	output logic [20:0]      O_BOOT_VECTOR,
	output logic [20:0]      O_WDOG_VECTOR,
	// decoded selects
	output logic             O_SEL_PF0,
	output logic             O_SEL_PF1,
	output logic             O_SEL_BOOT,
	output logic             O_SEL_PRAM,
	output logic             O_SEL_EXT,
	output logic             O_BLOCKED,
	// flash grants
	output logic [1:0]       O_PGM_GO,
	output logic [1:0]       O_ERASE_GO,
	output logic             O_DF_GNT_CORE,
	output logic             O_DF_GNT_SEC
);

	// ***************************************************************
	// pin synchronisers
	// ***************************************************************
	logic        boot_s1_reg;
	logic        boot_s2_reg;
	logic        wide_s1_reg;
	logic        wide_s2_reg;

	// first stage feeds only the second stage
	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			boot_s1_reg <= 1'b0;
			boot_s2_reg <= 1'b0;
			wide_s1_reg <= 1'b0;
			wide_s2_reg <= 1'b0;
		end
		else
		begin
			boot_s1_reg <= I_EXTERNAL_BOOT_PIN;
			boot_s2_reg <= boot_s1_reg;
			wide_s1_reg <= I_WIDE_ADDRESS_SELECT;
			wide_s2_reg <= wide_s1_reg;
		end
	end

	// ***************************************************************
	// startup sequencer
	// ***************************************************************
	bmpm_pkg::bmpm_state_e state_reg;
	logic [1:0]            wait_reg;

	// wait until the synchronisers hold real pin levels, then capture once
	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			state_reg <= bmpm_pkg::ST_SYNC;
			wait_reg  <= 2'h0;
		end
		else
		begin
			case (state_reg)
				bmpm_pkg::ST_SYNC:
				begin
					wait_reg <= wait_reg + 2'h1;
					if (wait_reg == 2'(bmpm_pkg::SYNC_STAGES - 1))
						state_reg <= bmpm_pkg::ST_CAPTURE;
				end
				bmpm_pkg::ST_CAPTURE:
					state_reg <= bmpm_pkg::ST_RUN;
				bmpm_pkg::ST_RUN:
					state_reg <= bmpm_pkg::ST_RUN;
				default:
					state_reg <= bmpm_pkg::ST_SYNC;
			endcase
		end
	end

	wire capture = (state_reg == bmpm_pkg::ST_CAPTURE);
	wire running = (state_reg == bmpm_pkg::ST_RUN);

	// ***************************************************************
	// operating mode bits
	// ***************************************************************
	logic secure_reg;
	logic map_sel_reg;
	logic wide_reg;

	// secure bit and width only change at the capture step
	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			secure_reg <= 1'b0;
			wide_reg   <= 1'b0;
		end
		else if (capture)
		begin
			secure_reg <= I_FLASH_UNSECURED;
			wide_reg   <= I_FLASH_UNSECURED & boot_s2_reg & wide_s2_reg;
		end
	end

	// secure bit writes are dropped; map select takes writes only while secure_reg is 1
	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
			map_sel_reg <= 1'b0;
		else if (capture)
			map_sel_reg <= boot_s2_reg & I_FLASH_UNSECURED;
		else if (running && I_OPMODE_WR && secure_reg)
			map_sel_reg <= I_OPMODE_BOOT_MAP_SELECT;
	end

	// ***************************************************************
	// map decode and bank guard
	// ***************************************************************
	bmpm_pkg::bmpm_tgt_e tgt;
	logic [20:0]         boot_vec;
	logic [20:0]         wdog_vec;
	logic [1:0]          fetch_bank;
	logic [1:0]          pgm_go;
	logic [1:0]          erase_go;

	bmpm_map_decode u_decode
	(
		.i_ready    (running),
		.i_map_ext  (map_sel_reg),
		.i_wide     (wide_reg),
		.i_addr     (I_PADDR),
		.o_tgt      (tgt),
		.o_boot_vec (boot_vec),
		.o_wdog_vec (wdog_vec)
	);

	// bank currently fetched from, seen by the guard
	assign fetch_bank[0] = I_PVALID && (tgt == bmpm_pkg::TGT_PF0);
	assign fetch_bank[1] = I_PVALID && (tgt == bmpm_pkg::TGT_PF1);

	bmpm_bank_guard #(.NB(bmpm_pkg::NUM_BANKS)) u_guard
	(
		.i_fetch     (fetch_bank),
		.i_pgm_req   (I_PGM_REQ),
		.i_erase_req (I_ERASE_REQ),
		.o_pgm_go    (pgm_go),
		.o_erase_go  (erase_go)
	);

	// ***************************************************************
	// status outputs
	// ***************************************************************
	// upper address lines 20..23 stay off in every mode; no write here turns them on
	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			O_READY            <= 1'b0;
			O_SECURE_STATE_BIT <= 1'b0;
			O_BOOT_MAP_SELECT  <= 1'b0;
			O_ADDR_WIDE        <= 1'b0;
			O_GPIO_AS_ADDR     <= bmpm_pkg::GPIO_ADDR_OFF;
			O_UPPER_ADDR_EN    <= bmpm_pkg::UPPER_ADDR_OFF;
			O_DEBUG_DISABLE    <= 1'b1;
			O_FIRST_CS_PROG_STROBE  <= 1'b1;
			O_SECOND_CS_DATA_STROBE <= 1'b1;
			O_BOOT_VECTOR      <= bmpm_pkg::BOOT_BASE;
			O_WDOG_VECTOR      <= bmpm_pkg::BOOT_BASE + bmpm_pkg::WDOG_OFS;
		end
		else
		begin
			O_READY            <= running;
			O_SECURE_STATE_BIT <= secure_reg;
			O_BOOT_MAP_SELECT  <= map_sel_reg;
			O_ADDR_WIDE        <= wide_reg;
			O_GPIO_AS_ADDR     <= wide_reg ? bmpm_pkg::GPIO_ADDR_ON : bmpm_pkg::GPIO_ADDR_OFF;
			O_UPPER_ADDR_EN    <= bmpm_pkg::UPPER_ADDR_OFF;
			O_DEBUG_DISABLE    <= ~secure_reg;
			O_FIRST_CS_PROG_STROBE  <= 1'b1;
			O_SECOND_CS_DATA_STROBE <= 1'b1;
			O_BOOT_VECTOR      <= boot_vec;
			O_WDOG_VECTOR      <= wdog_vec;
		end
	end

	// ***************************************************************
	// registered selects
	// ***************************************************************
	// one cycle of latency keeps every output on a flip-flop
	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			O_SEL_PF0  <= 1'b0;
			O_SEL_PF1  <= 1'b0;
			O_SEL_BOOT <= 1'b0;
			O_SEL_PRAM <= 1'b0;
			O_SEL_EXT  <= 1'b0;
			O_BLOCKED  <= 1'b0;
		end
		else
		begin
			O_SEL_PF0  <= I_PVALID && (tgt == bmpm_pkg::TGT_PF0);
			O_SEL_PF1  <= I_PVALID && (tgt == bmpm_pkg::TGT_PF1);
			O_SEL_BOOT <= I_PVALID && (tgt == bmpm_pkg::TGT_BOOT);
			O_SEL_PRAM <= I_PVALID && (tgt == bmpm_pkg::TGT_PRAM);
			O_SEL_EXT  <= I_PVALID && (tgt == bmpm_pkg::TGT_EXT);
			O_BLOCKED  <= I_PVALID && (tgt == bmpm_pkg::TGT_NONE);
		end
	end

	// ***************************************************************
	// flash grants
	// ***************************************************************
	// core bus wins a tie; secondary bus gets no grant that cycle
	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			O_PGM_GO      <= 2'h0;
			O_ERASE_GO    <= 2'h0;
			O_DF_GNT_CORE <= 1'b0;
			O_DF_GNT_SEC  <= 1'b0;
		end
		else
		begin
			O_PGM_GO      <= pgm_go;
			O_ERASE_GO    <= erase_go;
			O_DF_GNT_CORE <= I_DF_RD_CORE;
			O_DF_GNT_SEC  <= I_DF_RD_SEC & ~I_DF_RD_CORE;
		end
	end

	// ***************************************************************
	// assertions
	// ***************************************************************
	AST_SECURE_CAPTURE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		capture |=> (secure_reg == $past(I_FLASH_UNSECURED)))
		else $error("secure bit not loaded from flash state");

	AST_NO_EXT_WHEN_SECURE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		O_READY && !O_SECURE_STATE_BIT |-> !O_BOOT_MAP_SELECT && !O_ADDR_WIDE)
		else $error("external boot allowed while secured");

	AST_SECURED_LOCKDOWN: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		!secure_reg && I_PVALID && running |=> !O_SEL_EXT && O_DEBUG_DISABLE && (O_GPIO_AS_ADDR == 4'h0))
		else $error("secured mode reached external space or debug");

	AST_WIDTH_FROM_PIN: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		capture |=> ##1 (O_ADDR_WIDE == $past(I_FLASH_UNSECURED & boot_s2_reg & wide_s2_reg, 2)))
		else $error("address width does not follow sampled pin");

	AST_SECURE_STABLE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		running && $past(running) |-> $stable(secure_reg) && $stable(wide_reg))
		else $error("secure bit or width changed after reset");

	AST_MAP_LOCKED: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		running && !secure_reg && I_OPMODE_WR |=> $stable(map_sel_reg))
		else $error("map select written while locked");

	AST_MAP_WRITE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		running && secure_reg && I_OPMODE_WR |=> ##1 (O_BOOT_MAP_SELECT == $past(I_OPMODE_BOOT_MAP_SELECT, 2)))
		else $error("permitted map select write lost");

	AST_INT_VECTORS: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		running && !map_sel_reg |=> (O_BOOT_VECTOR == 21'h2_0000) && (O_WDOG_VECTOR == 21'h2_0002))
		else $error("internal boot vectors wrong");

	AST_EXT16_VECTORS: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		running && map_sel_reg && !wide_reg |=> (O_BOOT_VECTOR == 21'h0_0000) && (O_WDOG_VECTOR == 21'h0_0002))
		else $error("external 16-bit vectors wrong");

	AST_EXT20_OVERLAY: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		running && map_sel_reg && wide_reg && I_PVALID && (I_PADDR >= 21'h2_0000) && (I_PADDR <= 21'h2_1FFF)
		|=> O_SEL_EXT && !O_SEL_BOOT)
		else $error("boot flash not overlaid externally");

	AST_HIGH_BLOCKED: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		I_PVALID && (I_PADDR >= 21'h10_0000) |=> O_BLOCKED && !O_SEL_EXT)
		else $error("high program space reachable");

	AST_BANK_BUSY: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		O_PGM_GO[0] || O_ERASE_GO[0] |-> !$past(fetch_bank[0]))
		else $error("bank altered while fetched");

	AST_DF_EXCLUSIVE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		!(O_DF_GNT_CORE && O_DF_GNT_SEC))
		else $error("data flash granted to both buses");

	AST_LEGACY_CS: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
		O_FIRST_CS_PROG_STROBE && O_SECOND_CS_DATA_STROBE && (O_UPPER_ADDR_EN == 4'h0))
		else $error("chip selects left legacy mode");

endmodule

// ---- tb/bmpm_core_model.sv ----
// processor core model issuing fetches, mode writes and flash requests
`timescale 1ns/1ps
module bmpm_core_model
(
	// clock
	input  wire logic   i_clk,
	// mode register write
	output logic        o_opmode_wr,
	output logic        o_opmode_secure_state_bit,
	output logic        o_opmode_boot_map_select,
	// program fetch
	output logic        o_pvalid,
	output logic [20:0] o_paddr,
	// flash requests
	output logic [1:0]  o_pgm_req,
	output logic [1:0]  o_erase_req,
	output logic        o_df_rd_core,
	output logic        o_df_rd_sec
);
	// idle values; released address shows a changing pattern, not the last value
	initial
	begin
		o_opmode_wr               = 1'b0;
		o_opmode_secure_state_bit = 1'b0;
		o_opmode_boot_map_select  = 1'b0;
		o_pvalid               = 1'b0;
		o_paddr                = 21'h1_5555;
		o_pgm_req              = 2'b00;
		o_erase_req            = 2'b00;
		o_df_rd_core           = 1'b0;
		o_df_rd_sec            = 1'b0;
	end

	// one-cycle mode write; the core never sets the upper lines itself
	task automatic opmode_write(input logic map_sel, input logic sec_bit);
		@(posedge i_clk);
		#1;
		o_opmode_wr               = 1'b1;
		o_opmode_boot_map_select  = map_sel;
		o_opmode_secure_state_bit = sec_bit;
		@(posedge i_clk);
		#1;
		o_opmode_wr               = 1'b0;
		o_opmode_boot_map_select  = ~map_sel;
		o_opmode_secure_state_bit = ~sec_bit;
	endtask

	// one cycle of fetch and flash requests
	task automatic issue(input logic [20:0] a, input logic pv, input logic [1:0] pg,
		input logic [1:0] er, input logic dcore, input logic dsec);
		@(posedge i_clk);
		#1;
		o_pvalid     = pv;
		o_paddr      = a;
		o_pgm_req    = pg;
		o_erase_req  = er;
		o_df_rd_core = dcore;
		o_df_rd_sec  = dsec;
		@(posedge i_clk);
		#1;
		o_pvalid     = 1'b0;
		o_paddr      = ~a;
		o_pgm_req    = 2'b00;
		o_erase_req  = 2'b00;
		o_df_rd_core = 1'b0;
		o_df_rd_sec  = 1'b0;
	endtask
endmodule

// ---- tb/bmpm_top_tb_top.sv ----
// self-checking bench for boot mode capture and program map decode
`timescale 1ns/1ps
`define CHK(act, exp) begin compares++; if ((act) !== (exp)) begin miscompares++; \
	$display("[ERR] %0t value %h expected %h", $time, act, exp); end end
module bmpm_top_tb_top;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        boot_pin = 1'b0;
	logic        wide_pin = 1'b0;
	logic        unsec = 1'b0;
	logic        opm_wr, opm_sec, opm_map, pvalid, df_core, df_sec;
	logic [20:0] paddr;
	logic [1:0]  pgm_req, erase_req, pgm_go, erase_go;
	logic        rdy, sec, map_out, wide, dbg, cs_prog, cs_data, gnt_core, gnt_sec;
	logic [3:0]  gpio, upper;
	logic [20:0] bootv, wdogv;
	logic [5:0]  sel;
	logic        e_sec, e_map, e_w;
	int          compares = 0;
	int          miscompares = 0;
	logic [20:0] addrs [10] = '{21'h0_0000, 21'h0_FFFF, 21'h1_0000, 21'h2_0002, 21'h2_1FFF,
		21'h2_2000, 21'h2_F800, 21'h3_0000, 21'h0F_FFFF, 21'h10_0000};

	// 200 MHz clock
	always #2.5 clk = ~clk;

	bmpm_core_model core
	(
		.i_clk                  (clk),
		.o_opmode_wr               (opm_wr),
		.o_opmode_secure_state_bit (opm_sec),
		.o_opmode_boot_map_select  (opm_map),
		.o_pvalid               (pvalid),
		.o_paddr                (paddr),
		.o_pgm_req              (pgm_req),
		.o_erase_req            (erase_req),
		.o_df_rd_core           (df_core),
		.o_df_rd_sec            (df_sec)
	);

	bmpm_top uut
	(
		.I_CLK (clk), .I_RESETN (resetn), .I_EXTERNAL_BOOT_PIN (boot_pin),
		.I_WIDE_ADDRESS_SELECT (wide_pin), .I_FLASH_UNSECURED (unsec), .I_OPMODE_WR (opm_wr),
		.I_OPMODE_SECURE_STATE_BIT (opm_sec), .I_OPMODE_BOOT_MAP_SELECT (opm_map), .I_PVALID (pvalid),
		.I_PADDR (paddr), .I_PGM_REQ (pgm_req), .I_ERASE_REQ (erase_req), .I_DF_RD_CORE (df_core),
		.I_DF_RD_SEC (df_sec), .O_READY (rdy), .O_SECURE_STATE_BIT (sec), .O_BOOT_MAP_SELECT (map_out),
		.O_ADDR_WIDE (wide), .O_GPIO_AS_ADDR (gpio), .O_UPPER_ADDR_EN (upper), .O_DEBUG_DISABLE (dbg),
		.O_FIRST_CS_PROG_STROBE (cs_prog), .O_SECOND_CS_DATA_STROBE (cs_data),
		.O_BOOT_VECTOR (bootv), .O_WDOG_VECTOR (wdogv),
		.O_SEL_PF0 (sel[0]), .O_SEL_PF1 (sel[1]), .O_SEL_BOOT (sel[2]), .O_SEL_PRAM (sel[3]),
		.O_SEL_EXT (sel[4]), .O_BLOCKED (sel[5]), .O_PGM_GO (pgm_go), .O_ERASE_GO (erase_go),
		.O_DF_GNT_CORE (gnt_core), .O_DF_GNT_SEC (gnt_sec)
	);

	// expected one-hot target {blocked,ext,pram,boot,pf1,pf0}
	function automatic logic [5:0] exp_tgt(input logic [20:0] a, input logic m, input logic w);
		if (a <= 21'h0_FFFF) return m ? 6'h10 : 6'h01;
		if (a <= 21'h1_FFFF) return 6'h02;
		if (a <= 21'h2_1FFF) return (m & w) ? 6'h10 : 6'h04;
		if (a <= 21'h2_F7FF) return 6'h20;
		if (a <= 21'h2_FFFF) return 6'h08;
		if (a <= 21'h0F_FFFF) return (m & w) ? 6'h10 : 6'h20;
		return 6'h20;
	endfunction

	// verdict in one place
	task automatic finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// reset with pins set, then a bounded wait for ready
	task automatic apply_reset(input logic u, input logic b, input logic w);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		resetn   = 1'b0;
		unsec    = u;
		boot_pin = b;
		wide_pin = w;
		repeat (8) @(posedge clk);
		#1;
		`CHK({rdy, dbg, cs_prog, cs_data}, 4'h7)
		resetn = 1'b1;
		while (rdy !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 20)
		begin
			miscompares++;
			$display("[ERR] %0t ready wait ran out", $time);
			finish_test();
		end
	endtask

	// mode outputs against the expected captured state
	task automatic check_mode();
		logic [20:0] bv;
		bv = (e_map & ~e_w) ? 21'h0_0000 : 21'h2_0000;
		`CHK(rdy, 1'b1)
		`CHK(sec, e_sec)
		`CHK(map_out, e_map)
		`CHK(wide, e_w)
		`CHK(gpio, e_w ? 4'hF : 4'h0)
		`CHK(upper, 4'h0)
		`CHK(dbg, ~e_sec)
		`CHK({cs_prog, cs_data}, 2'b11)
		`CHK(bootv, bv)
		`CHK(wdogv, bv + 21'h0_0002)
	endtask

	// fetch ten addresses across the regions, one issue call each
	task automatic decode_sweep();
		foreach (addrs[i])
		begin
			core.issue(addrs[i], 1'b1, 2'b00, 2'b00, 1'b0, 1'b0);
			`CHK(sel, exp_tgt(addrs[i], e_map, e_w))
		end
	endtask

	// all eight pin and security combinations, then flash arbitration
	initial
	begin
		for (int m = 0; m < 8; m++)
		begin
			e_sec = m[2];
			e_map = m[2] & m[1];
			e_w   = m[2] & m[1] & m[0];
			apply_reset(m[2], m[1], m[0]);
			check_mode();
			decode_sweep();
			// security change after capture must not show until next reset
			@(posedge clk);
			#1;
			unsec = ~unsec;
			repeat (3) @(posedge clk);
			#1;
			check_mode();
			// map write with inverted secure data; refused when captured secure bit is 0
			core.opmode_write(~e_map, ~e_sec);
			repeat (2) @(posedge clk);
			#1;
			if (e_sec)
				e_map = ~e_map;
			check_mode();
			decode_sweep();
			$display("test mode %0d done", m);
		end
		// bank guard and data flash arbitration
		core.issue(21'h1_0000, 1'b1, 2'b11, 2'b11, 1'b1, 1'b1);
		`CHK({pgm_go, erase_go}, 4'h5)
		`CHK({gnt_core, gnt_sec}, 2'b10)
		core.issue(21'h0_0004, 1'b1, 2'b11, 2'b01, 1'b0, 1'b1);
		`CHK({pgm_go, erase_go}, 4'h8)
		`CHK({gnt_core, gnt_sec}, 2'b01)
		core.issue(21'h0_0004, 1'b0, 2'b10, 2'b01, 1'b1, 1'b0);
		`CHK({pgm_go, erase_go}, 4'h9)
		`CHK({gnt_core, gnt_sec}, 2'b10)
		$display("test flash done");
		finish_test();
	end
endmodule
